// File: rtl/eeb_pkg.sv
/*
  Shared constants and types for the two-wire serial EEPROM link: timing
  counts, address fields, memory geometry and the state encodings of both ends.
  Assumes the device end runs on the 32 ns link clock and the master on 40 ns.
*/
// ============================================================
// Package
// ============================================================
package eeb_pkg;

  // Clock periods of the two ends
  localparam int LINK_PERIOD_NS = 32;
  localparam int CLK_PERIOD_NS = 40;

  // Input glitch suppression: a pulse narrower than the width can never
  // cover this many link samples, so it is never accepted
  localparam int GLITCH_FILTER_WIDTH_NS = 100;
  localparam int GLITCH_CYCLES = (GLITCH_FILTER_WIDTH_NS - 1) / LINK_PERIOD_NS + 2;

  // Self-timed program cycle, longest time in link cycles, less the delay
  // with which a STOP on the pins reaches the engine
  localparam int INTERNAL_PROGRAM_TIME_MS = 10;
  localparam int PROG_CYCLES_DEF =
    (INTERNAL_PROGRAM_TIME_MS * 1000000) / LINK_PERIOD_NS - GLITCH_CYCLES - 3;

  // One quarter of a 10 us bit slot at the master, rounded up
  localparam int QUARTER_NS = 2500;
  localparam int QUARTER_CYCLES = (QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Slave address and memory geometry
  localparam logic [3:0] DEV_TYPE = 4'hA;
  localparam int PAGE_BYTES = 16;
  localparam int MEM_BYTES = 256;
  localparam logic [7:0] MEM_RESET = 8'hFF;
  localparam logic [2:0] STRAP_RESET = 3'h0;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // Device end states
  typedef enum logic [2:0] {
    D_IDLE = 3'b000, D_RX = 3'b001, D_ACK = 3'b010, D_TX = 3'b011,
    D_TXACK = 3'b100, D_WAIT = 3'b101, D_PROG = 3'b110
  } eeb_dev_e;

  // Which byte the device is receiving
  typedef enum logic [1:0] {
    PH_SLAVE = 2'b00, PH_WORD = 2'b01, PH_DATA = 2'b10
  } eeb_phase_e;

  // Master end states
  typedef enum logic [1:0] {
    H_IDLE = 2'b00, H_START = 2'b01, H_BIT = 2'b10, H_STOP = 2'b11
  } eeb_host_e;

endpackage

// File: rtl/eeb_if.sv
/*
  The two-wire bus between master and EEPROM device, with a modport for each.
  Open-drain wires are resolved here from the enables, with pull-ups implied.
*/
// ============================================================
// Bus interface
// ============================================================
interface eeb_if;
  logic scl_o;        // Master clock drive value
  logic scl_oe;       // Master pulls clock
  logic host_sda_o;   // Master data drive value
  logic host_sda_oe;  // Master pulls data
  logic dev_sda_o;    // Device data drive value
  logic dev_sda_oe;   // Device pulls data
  logic scl;          // Resolved clock line
  logic sda;          // Resolved data line

  // Wired-AND with pull-up
  assign scl = ~(scl_oe & ~scl_o);
  assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

  modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
  modport host (input scl, input sda, output scl_o, output scl_oe,
                output host_sda_o, output host_sda_oe);
endinterface

// File: rtl/eeb_glitch_filter.sv
/*
  Two-flop synchroniser followed by a stability filter for one bus pin.
  Assumes the pin idles high and is asynchronous to the clock.
*/
// ============================================================
// Glitch filter
// ============================================================
module eeb_glitch_filter
  import eeb_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Pin and clean level
  input wire logic raw,
  output logic filt
);
  logic s1_ff;       // First synchroniser stage
  logic s2_ff;       // Second synchroniser stage
  logic filt_ff;     // Accepted level
  logic [3:0] cnt_ff; // Cycles the new level has held

  // Synchroniser, first stage read only by the second
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_ff <= 1'b1;
      s2_ff <= 1'b1;
    end else begin
      s1_ff <= raw;
      s2_ff <= s1_ff;
    end
  end

  // Accept a change only after it has held long enough
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      filt_ff <= 1'b1;
      cnt_ff <= 4'h0;
    end else if (s2_ff == filt_ff) begin
      cnt_ff <= 4'h0; // Short pulse dropped, see (R15)
    end else if (cnt_ff == 4'(GLITCH_CYCLES - 1)) begin
      filt_ff <= s2_ff;
      cnt_ff <= 4'h0;
    end else begin
      cnt_ff <= cnt_ff + 4'h1;
    end
  end

  assign filt = filt_ff;
endmodule // eeb_glitch_filter

// File: rtl/eeb_eeprom_dev.sv
/*
  Device end of the two-wire link: a 2 Kbit serial EEPROM slave with
  START/STOP framing, address match, acknowledge, page write and read.
  Assumes it is clocked by the link clock and that the master keeps its side.
*/
// ============================================================
// Overview of operation
// (R1) STOP after write runs timed program cycle
// (R2) Program cycle: bus ignored, SDA released
// (R3) Master opens transactions with START
// (R4) Master ends transactions with STOP
// (R5) First byte: type, select, direction
// (R6) Upper four bits must equal 1010
// (R7) Select field must equal strap pins
// (R8) Last address bit: one read, zero write
// (R9) Receiver pulls SDA low on ninth clock
// (R10) Transmitter releases SDA for acknowledge
// (R11) Receiver acknowledges unless ending transfer
// (R12) Word address picks one of 256 bytes
// (R13) Page is sixteen aligned bytes
// (R14) One block of sixteen pages
// (R15) Short pulses on SCL, SDA ignored
// (R16) START is SDA fall with SCL high
// (R17) STOP is SDA rise with SCL high
// (R18) Data sampled while SCL high
// (R19) No master acknowledge: stop sending, await STOP
// (R20) Address mismatch: stay off bus
// ============================================================
module eeb_eeprom_dev
  import eeb_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = PROG_CYCLES_DEF // Program time in link cycles
) (
  // Link clock and reset
  input wire logic link_clk,
  input wire logic nrst,
  // Bus
  eeb_if.dev bus,
  // Device select straps
  input wire logic select_strap_bit0,
  input wire logic select_strap_bit1,
  input wire logic select_strap_bit2,
  // Status
  output logic write_busy
);

  // ==========================================================
  // Declarations
  // ==========================================================
  logic scl_f;              // Clean clock line
  logic sda_f;              // Clean data line
  logic scl_d_ff;           // Clock line one cycle ago
  logic sda_d_ff;           // Data line one cycle ago
  logic scl_rise;           // Clock rising edge
  logic scl_fall;           // Clock falling edge
  logic start_det;          // START seen
  logic stop_det;           // STOP seen
  logic [2:0] strap_s1_ff;  // Strap synchroniser first stage
  logic [2:0] strap_ff;     // Synchronised straps
  eeb_dev_e state_ff;       // Protocol state
  eeb_phase_e phase_ff;     // Byte being received
  logic [3:0] cnt_ff;       // Bit counter
  logic [7:0] sh_ff;        // Receive shifter
  logic [7:0] tx_ff;        // Transmit shifter
  logic [7:0] ptr_ff;       // Array address pointer
  logic rw_ff;              // Direction bit of last address
  logic wr_pend_ff;         // Data byte taken in this write
  logic sda_oe_ff;          // Pulling data low
  logic [31:0] timer_ff;    // Program cycle counter
  logic [7:0] mem_ff [MEM_BYTES];    // Array storage
  logic [7:0] pbuf_ff [PAGE_BYTES];  // Page latches
  logic [PAGE_BYTES-1:0] pmask_ff;   // Latches loaded this write
  logic data_acc;           // A data byte is accepted now
  logic prog_done;          // Last cycle of the program cycle

  // ==========================================================
  // Pin conditioning
  // ==========================================================
  eeb_glitch_filter u_scl_filt (
    .clk (link_clk),
    .nrst (nrst),
    .raw (bus.scl),
    .filt (scl_f)
  );

  eeb_glitch_filter u_sda_filt (
    .clk (link_clk),
    .nrst (nrst),
    .raw (bus.sda),
    .filt (sda_f)
  );

  // Previous line levels for edge detection
  always_ff @(posedge link_clk or negedge nrst) begin
    if (!nrst) begin
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      scl_d_ff <= scl_f;
      sda_d_ff <= sda_f;
    end
  end

  // Straps are pins, so they are synchronised too
  always_ff @(posedge link_clk or negedge nrst) begin
    if (!nrst) begin
      strap_s1_ff <= STRAP_RESET;
      strap_ff <= STRAP_RESET;
    end else begin
      strap_s1_ff <= {select_strap_bit2, select_strap_bit1, select_strap_bit0};
      strap_ff <= strap_s1_ff;
    end
  end

  // Edges and bus conditions
  assign scl_rise = scl_f & ~scl_d_ff;  // Data sampled here, see (R18)
  assign scl_fall = ~scl_f & scl_d_ff;
  assign start_det = scl_f & scl_d_ff & sda_d_ff & ~sda_f;  // see (R16)
  assign stop_det = scl_f & scl_d_ff & ~sda_d_ff & sda_f;   // see (R17)

  assign data_acc = (state_ff == D_RX) && scl_fall && (cnt_ff == BITS_PER_BYTE)
                    && (phase_ff == PH_DATA) && !start_det && !stop_det;
  assign prog_done = (state_ff == D_PROG) && (timer_ff == PROG_CYCLES - 1);

  // ==========================================================
  // Protocol engine
  // ==========================================================
  // Bus conditions win over bit activity; the program cycle sees nothing
  always_ff @(posedge link_clk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= D_IDLE;
      phase_ff <= PH_SLAVE;
      cnt_ff <= 4'h0;
      sh_ff <= 8'h00;
      tx_ff <= 8'hFF;
      ptr_ff <= 8'h00;
      rw_ff <= 1'b0;
      wr_pend_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
    end else if (state_ff == D_PROG) begin
      sda_oe_ff <= 1'b0; // Line left to the pull-up, see (R2)
      if (prog_done) begin
        state_ff <= D_IDLE;
      end
    end else if (stop_det) begin
      // Write sequence ends in the program cycle, see (R1)
      state_ff <= wr_pend_ff ? D_PROG : D_IDLE;
      wr_pend_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
    end else if (start_det) begin
      // Any START, repeated or not, begins a new address byte
      state_ff <= D_RX;
      phase_ff <= PH_SLAVE;
      cnt_ff <= 4'h0;
      wr_pend_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
    end else begin
      unique case (state_ff)
        D_IDLE, D_WAIT: begin
          // Waiting for START, off the bus
          sda_oe_ff <= 1'b0;
        end
        D_RX: begin
          if (scl_rise) begin
            sh_ff <= {sh_ff[6:0], sda_f};
            cnt_ff <= cnt_ff + 4'h1;
          end else if (scl_fall && cnt_ff == BITS_PER_BYTE) begin
            unique case (phase_ff)
              PH_SLAVE: begin
                // Type and straps must both match, see (R5) (R6) (R7)
                if (sh_ff[7:4] == DEV_TYPE && sh_ff[3:1] == strap_ff) begin
                  state_ff <= D_ACK;
                  sda_oe_ff <= 1'b1; // see (R9)
                  rw_ff <= sh_ff[0]; // see (R8)
                end else begin
                  state_ff <= D_WAIT; // see (R20)
                end
              end
              PH_WORD: begin
                // Full 8-bit address, single block, see (R12) (R14)
                ptr_ff <= sh_ff;
                state_ff <= D_ACK;
                sda_oe_ff <= 1'b1; // see (R9) (R11)
              end
              default: begin
                // Data byte; pointer wraps inside its page, see (R13)
                ptr_ff <= {ptr_ff[7:4], ptr_ff[3:0] + 4'h1};
                wr_pend_ff <= 1'b1;
                state_ff <= D_ACK;
                sda_oe_ff <= 1'b1; // see (R11)
              end
            endcase
          end
        end
        D_ACK: begin
          // Release at the end of the ninth clock, see (R9)
          if (scl_fall) begin
            cnt_ff <= 4'h0;
            if (phase_ff == PH_SLAVE && rw_ff) begin
              // Read: first bit goes out at once
              state_ff <= D_TX;
              tx_ff <= mem_ff[ptr_ff];
              sda_oe_ff <= ~mem_ff[ptr_ff][7];
              ptr_ff <= ptr_ff + 8'h01;
            end else begin
              state_ff <= D_RX;
              phase_ff <= (phase_ff == PH_SLAVE) ? PH_WORD : PH_DATA;
              sda_oe_ff <= 1'b0;
            end
          end
        end
        D_TX: begin
          // Bits change only while the clock is low
          if (scl_fall) begin
            cnt_ff <= cnt_ff + 4'h1;
            if (cnt_ff == BITS_PER_BYTE - 4'h1) begin
              state_ff <= D_TXACK;
              sda_oe_ff <= 1'b0; // see (R10)
            end else begin
              tx_ff <= {tx_ff[6:0], 1'b1};
              sda_oe_ff <= ~tx_ff[6];
            end
          end
        end
        D_TXACK: begin
          if (scl_rise && sda_f) begin
            state_ff <= D_WAIT; // No acknowledge, see (R19)
          end else if (scl_fall) begin
            // Acknowledged: next byte, pointer runs over the whole block
            state_ff <= D_TX;
            cnt_ff <= 4'h0;
            tx_ff <= mem_ff[ptr_ff];
            sda_oe_ff <= ~mem_ff[ptr_ff][7];
            ptr_ff <= ptr_ff + 8'h01;
          end
        end
        default: begin
          // Unused code, fall back to idle
          state_ff <= D_IDLE;
          sda_oe_ff <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // Program cycle timer
  // ==========================================================
  always_ff @(posedge link_clk or negedge nrst) begin
    if (!nrst) begin
      timer_ff <= 32'h0;
    end else if (state_ff == D_PROG) begin
      timer_ff <= timer_ff + 32'h1; // see (R1)
    end else begin
      timer_ff <= 32'h0;
    end
  end

  // ==========================================================
  // Page latches and array
  // ==========================================================
  // Latches collect one page; a new START drops a half-done write
  always_ff @(posedge link_clk or negedge nrst) begin
    if (!nrst) begin
      pbuf_ff <= '{default: MEM_RESET};
      pmask_ff <= '0;
    end else if (start_det && state_ff != D_PROG) begin
      pmask_ff <= '0;
    end else if (data_acc) begin
      pbuf_ff[ptr_ff[3:0]] <= sh_ff;  // see (R13)
      pmask_ff[ptr_ff[3:0]] <= 1'b1;
    end else if (prog_done) begin
      pmask_ff <= '0;
    end
  end

  // Latches loaded this write land in the array as the program cycle ends
  always_ff @(posedge link_clk or negedge nrst) begin
    if (!nrst) begin
      mem_ff <= '{default: MEM_RESET};
    end else if (prog_done) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        if (pmask_ff[i]) begin
          mem_ff[{ptr_ff[7:4], 4'(i)}] <= pbuf_ff[i]; // see (R13) (R14)
        end
      end
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  assign bus.dev_sda_o = 1'b0;         // Open drain: only ever pulls low
  assign bus.dev_sda_oe = sda_oe_ff;
  assign write_busy = (state_ff == D_PROG);

endmodule // eeb_eeprom_dev

// File: rtl/eeb_bus_master.sv
/*
  Master end of the two-wire link: runs one byte write or one random read
  per command. Makes SCL by dividing its own clock; no clock stretching.
*/
// ============================================================
// Bus master
// ============================================================
module eeb_bus_master
  import eeb_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Bus
  eeb_if.host bus,
  // Command
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_read,
  input wire logic [2:0] cmd_sel,
  input wire logic [7:0] cmd_addr,
  input wire logic [7:0] cmd_wdata,
  // Response
  output logic rsp_valid,
  output logic rsp_ack_ok,
  output logic [7:0] rsp_rdata
);
  eeb_host_e state_ff;      // Sequencer state
  logic [1:0] q_ff;         // Quarter of the bit slot
  logic [6:0] div_ff;       // Quarter divider
  logic tick;               // End of a quarter
  logic [3:0] bit_ff;       // Bit within byte, 8 is acknowledge
  logic [1:0] byte_ff;      // 0 slave W, 1 addr, 2 data or slave R, 3 read data
  logic [7:0] sh_ff;        // Shift register
  logic rd_ff;              // Command is a read
  logic [2:0] sel_ff;       // Select field
  logic [7:0] addr_ff;      // Word address
  logic [7:0] wdata_ff;     // Write data
  logic scl_oe_ff;          // Pulling clock low
  logic sda_oe_ff;          // Pulling data low
  logic sda_s1_ff;          // Data synchroniser first stage
  logic sda_s_ff;           // Synchronised data
  logic ack_ok_ff;          // Every byte sent was acknowledged
  logic rsp_valid_ff;       // Response pulse
  logic [7:0] rdata_ff;     // Read result
  logic rx_byte;            // Current byte comes from the device

  // Byte to send at a given position of the sequence
  function automatic logic [7:0] byte_val(input logic [1:0] idx, input logic rd,
                                          input logic [2:0] sel, input logic [7:0] addr,
                                          input logic [7:0] wdata);
    unique case (idx)
      2'd0: byte_val = {DEV_TYPE, sel, 1'b0};       // see (R5) (R8)
      2'd1: byte_val = addr;                        // see (R12)
      2'd2: byte_val = rd ? {DEV_TYPE, sel, 1'b1} : wdata;
      default: byte_val = 8'hFF;                    // Released while reading
    endcase
  endfunction

  assign tick = (div_ff == 7'(QUARTER_CYCLES - 1));
  assign rx_byte = (byte_ff == 2'd3);

  // Quarter divider, idle outside a transaction
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div_ff <= 7'h00;
    end else if (state_ff == H_IDLE || tick) begin
      div_ff <= 7'h00;
    end else begin
      div_ff <= div_ff + 7'h01;
    end
  end

  // Data line comes back through two flops
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sda_s1_ff <= 1'b1;
      sda_s_ff <= 1'b1;
    end else begin
      sda_s1_ff <= bus.sda;
      sda_s_ff <= sda_s1_ff;
    end
  end

  // ==========================================================
  // Sequencer
  // ==========================================================
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= H_IDLE;
      q_ff <= 2'd0;
      bit_ff <= 4'h0;
      byte_ff <= 2'd0;
      sh_ff <= 8'h00;
      rd_ff <= 1'b0;
      sel_ff <= 3'h0;
      addr_ff <= 8'h00;
      wdata_ff <= 8'h00;
      scl_oe_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
      ack_ok_ff <= 1'b0;
      rsp_valid_ff <= 1'b0;
      rdata_ff <= 8'h00;
    end else if (state_ff == H_IDLE) begin
      rsp_valid_ff <= 1'b0;
      q_ff <= 2'd0;
      if (cmd_valid) begin
        state_ff <= H_START; // see (R3)
        byte_ff <= 2'd0;
        rd_ff <= cmd_read;
        sel_ff <= cmd_sel;
        addr_ff <= cmd_addr;
        wdata_ff <= cmd_wdata;
        ack_ok_ff <= 1'b1;
      end
    end else if (tick) begin
      q_ff <= q_ff + 2'd1;
      unique case (state_ff)
        H_START: begin
          // Data falls while clock is high, see (R16)
          unique case (q_ff)
            2'd0: sda_oe_ff <= 1'b0;
            2'd1: scl_oe_ff <= 1'b0;
            2'd2: sda_oe_ff <= 1'b1;
            default: begin
              scl_oe_ff <= 1'b1;
              state_ff <= H_BIT;
              bit_ff <= 4'h0;
              sh_ff <= byte_val(byte_ff, rd_ff, sel_ff, addr_ff, wdata_ff);
            end
          endcase
        end
        H_BIT: begin
          unique case (q_ff)
            // Change data with clock low; release for the ack, see (R10) (R18)
            2'd0: sda_oe_ff <= !rx_byte && bit_ff != BITS_PER_BYTE && !sh_ff[7];
            2'd1: scl_oe_ff <= 1'b0;
            2'd2: begin
              if (bit_ff != BITS_PER_BYTE) begin
                sh_ff <= {sh_ff[6:0], sda_s_ff};
              end else if (!rx_byte && sda_s_ff) begin
                ack_ok_ff <= 1'b0; // No acknowledge from the device
              end
            end
            default: begin
              scl_oe_ff <= 1'b1;
              if (bit_ff != BITS_PER_BYTE) begin
                bit_ff <= bit_ff + 4'h1;
              end else if (!ack_ok_ff || rx_byte || (byte_ff == 2'd2 && !rd_ff)) begin
                // Read byte is left unacknowledged to end it, see (R11)
                state_ff <= H_STOP;
              end else if (byte_ff == 2'd1 && rd_ff) begin
                state_ff <= H_START; // Repeated START before slave R
                byte_ff <= 2'd2;
              end else begin
                byte_ff <= byte_ff + 2'd1;
                bit_ff <= 4'h0;
                sh_ff <= byte_val(byte_ff + 2'd1, rd_ff, sel_ff, addr_ff, wdata_ff);
              end
            end
          endcase
        end
        default: begin
          // Data rises while clock is high, see (R4) (R17)
          unique case (q_ff)
            2'd0: sda_oe_ff <= 1'b1;
            2'd1: scl_oe_ff <= 1'b0;
            2'd2: sda_oe_ff <= 1'b0;
            default: begin
              state_ff <= H_IDLE;
              rsp_valid_ff <= 1'b1;
              rdata_ff <= sh_ff;
            end
          endcase
        end
      endcase
    end
  end

  // Outputs
  assign cmd_ready = (state_ff == H_IDLE);
  assign rsp_valid = rsp_valid_ff;
  assign rsp_ack_ok = ack_ok_ff;
  assign rsp_rdata = rdata_ff;
  assign bus.scl_o = 1'b0;
  assign bus.scl_oe = scl_oe_ff;
  assign bus.host_sda_o = 1'b0;
  assign bus.host_sda_oe = sda_oe_ff;

endmodule // eeb_bus_master

// File: bench/eeb_link_chk.sv
/* Assertions on the two-wire link between master and device.
   Assumes it sits beside the bus interface and sees both clocks. */
// ============================================================
// Checker
// ============================================================
module eeb_link_chk
  import eeb_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = PROG_CYCLES_DEF // Program time in link cycles
) (
  // Clocks and reset
  input wire logic clk,
  input wire logic link_clk,
  input wire logic nrst,
  // Lines and drives
  input wire logic scl,
  input wire logic sda,
  input wire logic dev_sda_oe,
  // Status
  input wire logic write_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned busy_cnt_ff; // Link cycles spent busy so far

  // Counts the program cycle; clears whenever idle
  always_ff @(posedge link_clk or negedge nrst) begin
    if (!nrst) begin
      busy_cnt_ff <= 0;
    end else begin
      busy_cnt_ff <= write_busy ? busy_cnt_ff + 1 : 0;
    end
  end

  // Framing conditions on the resolved lines
  sequence start_seen;
    $fell(sda) && scl;
  endsequence
  sequence stop_seen;
    $rose(sda) && scl;
  endsequence

  AST_START_HOLD: assert property (@(posedge clk) disable iff (!nrst)
    start_seen |=> scl [*8]) else $error("clock fell right after start");
  AST_STOP_IDLE: assert property (@(posedge clk) disable iff (!nrst)
    stop_seen |=> (scl && sda) [*8]) else $error("bus not idle after stop");
  AST_BUSY_LEN: assert property (@(posedge link_clk) disable iff (!nrst)
    $fell(write_busy) |-> busy_cnt_ff == PROG_CYCLES) else $error("program length wrong");
  AST_BUSY_QUIET: assert property (@(posedge link_clk) disable iff (!nrst)
    write_busy |-> !dev_sda_oe) else $error("data driven while programming");
  AST_BUSY_FROM_IDLE: assert property (@(posedge link_clk) disable iff (!nrst)
    $rose(write_busy) |-> scl && sda) else $error("program began off a stop");
  AST_DEV_EDGE: assert property (@(posedge link_clk) disable iff (!nrst)
    $changed(dev_sda_oe) |-> !scl) else $error("device moved data with clock high");
  AST_ACK_LOW: assert property (@(posedge link_clk) disable iff (!nrst)
    $rose(dev_sda_oe) |-> (!scl) [*8]) else $error("device pull too late in low phase");
  // Sync plus filter delay: the clock must have been low six samples back
  AST_FILTER_LAG: assert property (@(posedge link_clk) disable iff (!nrst)
    $rose(dev_sda_oe) |-> $past(scl, 6) == 1'b0) else $error("device reacted too early");
endmodule // eeb_link_chk

// File: bench/testbench.sv
/* Bench: master and device joined by the bus interface, checker beside it.
   Assumes the package, interface and design modules are compiled first. */
// ============================================================
// Testbench
// ============================================================
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import eeb_pkg::*;
  localparam int unsigned PROG = 4000; // Long enough to catch a write mid-program
  logic clk = 1'b0;
  logic link_clk = 1'b0;
  logic nrst = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_read = 1'b0;
  logic [2:0] cmd_sel = 3'h0;
  logic [7:0] cmd_addr = 8'h00;
  logic [7:0] cmd_wdata = 8'h00;
  logic [2:0] strap = 3'h0; // Device select straps
  logic cmd_ready, rsp_valid, rsp_ack_ok, write_busy;
  logic [7:0] rsp_rdata, a, d;
  logic [9:0] notes[$]; // Expected {ack, data checked, data}
  logic [9:0] note;
  int failures = 0;
  int check_count = 0;

  always #20 clk = ~clk;
  always #16 link_clk = ~link_clk;

  eeb_if eeb_if_inst();
  eeb_bus_master eeb_bus_master_inst(.clk(clk), .nrst(nrst), .bus(eeb_if_inst),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_read(cmd_read), .cmd_sel(cmd_sel),
    .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
    .rsp_ack_ok(rsp_ack_ok), .rsp_rdata(rsp_rdata));
  eeb_eeprom_dev #(.PROG_CYCLES(PROG)) eeb_eeprom_dev_inst(.link_clk(link_clk), .nrst(nrst),
    .bus(eeb_if_inst), .select_strap_bit0(strap[0]), .select_strap_bit1(strap[1]),
    .select_strap_bit2(strap[2]), .write_busy(write_busy));
  eeb_link_chk #(.PROG_CYCLES(PROG)) eeb_link_chk_inst(.clk(clk), .link_clk(link_clk),
    .nrst(nrst), .scl(eeb_if_inst.scl), .sda(eeb_if_inst.sda),
    .dev_sda_oe(eeb_if_inst.dev_sda_oe), .write_busy(write_busy));

  // Issue one command and note its expected response
  task automatic run(input logic rd, input logic [2:0] sel, input logic [7:0] ad,
                     input logic [7:0] wd, input logic [9:0] exp);
    notes.push_back(exp);
    @(posedge clk); // Lets the previous drop of the request be seen first
    #2;
    cmd_valid = 1'b1;
    cmd_read = rd;
    cmd_sel = sel;
    cmd_addr = ad;
    cmd_wdata = wd;
    while (cmd_ready !== 1'b1) begin
      @(posedge clk);
      #2;
    end
    @(posedge clk);
    #2;
    cmd_valid = 1'b0;
  endtask

  // Compare each response pulse with the oldest note
  always @(negedge clk) begin
    if (rsp_valid === 1'b1) begin
      note = notes.pop_front();
      check_count++;
      if (rsp_ack_ok !== note[9] || (note[8] && rsp_rdata !== note[7:0])) begin
        failures++;
        $display("[FAIL] response expected %h seen %b %h", note, rsp_ack_ok, rsp_rdata);
      end
    end
  end

  // Verdict and end of run
  task automatic conclude;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Hang guard: about twice the expected run
  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    conclude();
  end

  // Main sequence; commands go back to back, except for the wait for the program cycle to end
  initial begin
    void'($urandom(78745));
    strap = 3'($urandom);
    a = 8'($urandom);
    d = 8'($urandom);
    repeat (2) @(posedge clk);
    #2;
    nrst = 1'b1;
    run(1'b0, strap, a, d, 10'h200);
    run(1'b0, strap, a + 8'h01, ~d, 10'h000);
    // Let the program cycle end so that the select compare is really made
    while (write_busy !== 1'b0) @(posedge clk);
    run(1'b0, strap ^ 3'h5, a, ~d, 10'h000);
    run(1'b1, strap, a, 8'h00, {2'b11, d});
    run(1'b1, strap, a + 8'h01, 8'h00, {2'b11, MEM_RESET});
    while (notes.size() != 0) @(posedge clk);
    conclude();
  end
endmodule // testbench
